// File: hdl/tas_defs.svh
// Constants of the touch acquisition sequencer: sizes, reset values, timing.
// Assumes a 10 MHz core clock and a 10-bit converter in the analog front end.
// Function
// RL1: Digitise the capacitor mid-point with 10-bit converter
// RL2: Calibrate every enabled button at power-up first
// RL3: Match compensation capacitor, target signal near 512
// RL4: Store matched signal as the button reference
// RL5: Repeat measurements at configured measurement period
// RL6: Delta equals signal minus stored reference
// RL7: Integrate detect before declaring touch above threshold
// RL8: Release below threshold minus hysteresis, after integration
// RL9: Freeze drift on all buttons while any touched
// RL10: Twelve physical buttons plus four lumped buttons
// RL11: Scan buttons one at a time, ascending
// RL12: Reset default enables buttons 0-11 only
// RL13: Skip disabled or suspended buttons in the scan
// RL14: All suspended triggers watchdog reset if enabled
// RL15: Shield mode removes button 11 from sensing
// RL16: Enable writes take effect after next reset
// RL17: Host writes enable, then persist, then restart
// RL18: Suspend removes button from scan at once
// RL19: Power-up clears suspends; host must reissue them
// RL20: Calibrate request recalibrates button next cycle
// RL21: Host should recalibrate after long suspension
// RL22: Hysteresis is a fraction of the threshold
// RL23: Calibrate bit clears itself when recalibration completes
`ifndef TAS_DEFS_SVH
`define TAS_DEFS_SVH

`define TAS_NBTN 16
`define TAS_ADC_W 10
`define TAS_CAP_W 8
`define TAS_DLT_W 11
`define TAS_EN_DEFAULT 16'h0FFF
`define TAS_SHIELD_MASK 16'h0800
`define TAS_LAST_BTN 4'hF
`define TAS_CAL_TARGET 10'h200
`define TAS_CAP_MID 8'h80
`define TAS_CAL_STEPS 4'h8
`define TAS_CLK_MHZ 10
`define TAS_TICK_US 100
`define TAS_TICK_CYCLES (`TAS_TICK_US * `TAS_CLK_MHZ)
`define TAS_WDT_US 200
`define TAS_WDT_CYCLES (`TAS_WDT_US * `TAS_CLK_MHZ)
`define TAS_CNT_W 12

`endif

// File: hdl/tas_detect.sv
// Touch decision for one button: threshold, hysteresis, detect integration.
// Purely combinational; the caller keeps touch state and counter per button.
`timescale 1ns/1ps
`default_nettype none

module tas_detect (
	input wire tas_pkg::tas_delta_t delta,
	input wire logic [7:0] threshold,
	input wire logic [1:0] hyst_sel,
	input wire logic [3:0] di_limit,
	input wire logic touched,
	input wire logic [3:0] count,
	output logic touched_nxt,
	output logic [3:0] count_nxt
);
	import tas_pkg::*;

	logic [7:0] hyst;
	logic [7:0] release_lvl;
	logic [3:0] di_eff;
	logic [3:0] cnt_inc;

	always_comb begin
		// Hysteresis is a power-of-two fraction: 1/2, 1/4, 1/8, 1/16
		hyst = threshold >> ({1'b0, hyst_sel} + 3'h1); // [RL22]
		release_lvl = threshold - hyst;
		// A zero limit would confirm at once anyway; it counts as one
		di_eff = (di_limit == 4'h0) ? 4'h1 : di_limit;
		cnt_inc = count + 4'h1;
		touched_nxt = touched;
		count_nxt = 4'h0;
		if (!touched) begin
			if (delta > $signed({3'h0, threshold})) begin // [RL7]
				if (cnt_inc >= di_eff) begin
					touched_nxt = 1'b1;
				end else begin
					count_nxt = cnt_inc;
				end
			end
		end else begin
			if (delta < $signed({3'h0, release_lvl})) begin // [RL8]
				if (cnt_inc >= di_eff) begin
					touched_nxt = 1'b0;
				end else begin
					count_nxt = cnt_inc;
				end
			end
		end
	end

endmodule // tas_detect

`default_nettype wire

// File: hdl/tas_pkg.sv
// Types of the touch acquisition sequencer: scan phases and the state record.
// Assumes tas_defs.svh is on the include path.
`include "tas_defs.svh"

package tas_pkg;

	typedef enum logic [1:0] {
		TAS_IDLE,
		TAS_CONVERT,
		TAS_WAIT,
		TAS_EVAL
	} tas_phase_e;

	typedef logic [`TAS_NBTN-1:0] tas_mask_t;
	typedef logic signed [`TAS_DLT_W-1:0] tas_delta_t;

	typedef struct packed {
		tas_phase_e phase;
		tas_mask_t en_pend;
		tas_mask_t en_saved;
		tas_mask_t en_act;
		tas_mask_t susp;
		tas_mask_t cal;
		tas_mask_t touch;
		logic [`TAS_NBTN-1:0][`TAS_ADC_W-1:0] refv;
		logic [`TAS_NBTN-1:0][3:0] dcnt;
		logic [`TAS_NBTN-1:0][`TAS_CAP_W-1:0] cap;
		logic [3:0] btn;
		logic [3:0] cal_step;
		logic [`TAS_CAP_W-1:0] cal_bit;
		logic [`TAS_CAP_W-1:0] cap_out;
		logic [3:0] adc_btn;
		logic adc_start;
		logic done_s1;
		logic done_s2;
		logic done_s3;
		logic [`TAS_ADC_W-1:0] data_s1;
		logic [`TAS_ADC_W-1:0] data_s2;
		logic [`TAS_ADC_W-1:0] sig;
		tas_delta_t delta;
		logic [`TAS_CNT_W-1:0] tick_cnt;
		logic [7:0] period_cnt;
		logic [`TAS_CNT_W-1:0] wdt_cnt;
		logic wdt_rst;
		logic init_done;
		logic drift_frozen;
	} tas_state_s;

endpackage

// File: hdl/tas_top.sv
// Touch acquisition sequencer: scan order, calibration, delta, detect, drift.
// Assumes an analog front end that converts on ADC_START and toggles
// ADC_DONE, and host register logic on CLK that drives the control ports.
`timescale 1ns/1ps
`default_nettype none
`include "tas_defs.svh"

module tas_top (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic EN_WR,
	input wire tas_pkg::tas_mask_t EN_DATA,
	input wire logic PERSIST,
	input wire logic RESTART,
	input wire logic SUSP_WR,
	input wire tas_pkg::tas_mask_t SUSP_DATA,
	input wire tas_pkg::tas_mask_t CAL_REQ,
	input wire logic SHIELD_MODE,
	input wire logic WDT_ENABLE,
	input wire logic [7:0] THRESHOLD,
	input wire logic [1:0] HYST_SEL,
	input wire logic [3:0] DI_LIMIT,
	input wire logic [7:0] MEAS_PERIOD,
	input wire logic ADC_DONE,
	input wire logic [`TAS_ADC_W-1:0] ADC_DATA,
	output logic ADC_START,
	output logic [3:0] ADC_BUTTON,
	output logic [`TAS_CAP_W-1:0] COMP_CAP,
	output tas_pkg::tas_mask_t TOUCH,
	output tas_pkg::tas_mask_t CAL_PENDING,
	output tas_pkg::tas_mask_t ENABLED,
	output tas_pkg::tas_mask_t SUSPENDED,
	output logic [`TAS_ADC_W-1:0] SIGNAL,
	output tas_pkg::tas_delta_t DELTA,
	output logic DRIFT_FROZEN,
	output logic CAL_DONE,
	output logic WDT_RESET
);
	import tas_pkg::*;

	tas_state_s st_r;
	tas_state_s st_nxt;

	tas_mask_t act_mask;
	tas_mask_t sense_mask;
	logic [4:0] nxt_hit;
	logic done_evt;
	logic tick;
	logic advance;
	logic stuck;
	logic wdt_fire;
	logic restart;
	logic [`TAS_CAP_W-1:0] trial;
	tas_delta_t cur_delta;
	logic det_touch;
	logic [3:0] det_cnt;

	// First set bit of mask at or above index from; bit 4 flags a hit
	function automatic logic [4:0] find_next(input tas_mask_t mask,
			input logic [4:0] from);
		logic [4:0] r;
		r = 5'h00;
		for (int i = `TAS_NBTN - 1; i >= 0; i--) begin
			if (i >= int'(from) && mask[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic tas_delta_t calc_delta(input logic [`TAS_ADC_W-1:0] s,
			input logic [`TAS_ADC_W-1:0] rv);
		return $signed({1'b0, s}) - $signed({1'b0, rv}); // [RL6]
	endfunction

	assign cur_delta = calc_delta(st_r.sig, st_r.refv[st_r.btn]);

	tas_detect u_detect (
		.delta(cur_delta),
		.threshold(THRESHOLD),
		.hyst_sel(HYST_SEL),
		.di_limit(DI_LIMIT),
		.touched(st_r.touch[st_r.btn]),
		.count(st_r.dcnt[st_r.btn]),
		.touched_nxt(det_touch),
		.count_nxt(det_cnt)
	);

	always_comb begin
		st_nxt = st_r;
		st_nxt.adc_start = 1'b0;
		st_nxt.wdt_rst = 1'b0;
		advance = 1'b0;
		nxt_hit = 5'h00;
		trial = st_r.cap[st_r.btn];

		// Three flops on the converter handshake; data is held by the front
		// end from before the toggle, so a bus sample is stable by the edge
		st_nxt.done_s1 = ADC_DONE;
		st_nxt.done_s2 = st_r.done_s1;
		st_nxt.done_s3 = st_r.done_s2;
		st_nxt.data_s1 = ADC_DATA;
		st_nxt.data_s2 = st_r.data_s1;
		done_evt = st_r.done_s2 ^ st_r.done_s3;

		// Base tick of the measurement period
		tick = (st_r.tick_cnt == `TAS_CNT_W'(`TAS_TICK_CYCLES - 1));
		st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + 1'b1;
		if (tick && st_r.period_cnt != 8'h00) begin
			st_nxt.period_cnt = st_r.period_cnt - 8'h01;
		end

		// Shield line and suspends drop out of the scan right away
		sense_mask = st_r.en_act & ~(SHIELD_MODE ? `TAS_SHIELD_MASK : '0); // [RL15]
		act_mask = sense_mask & ~st_r.susp; // [RL13] [RL18]

		// Enable writes wait in a pending copy, then a saved copy, until a restart
		if (EN_WR) begin
			st_nxt.en_pend = EN_DATA; // [RL16]
		end
		if (PERSIST) begin
			st_nxt.en_saved = st_r.en_pend; // [RL17]
		end
		if (SUSP_WR) begin
			st_nxt.susp = SUSP_DATA; // [RL18]
		end

		unique case (st_r.phase)
			TAS_IDLE: begin
				// One pass per period, always from button 0 upward
				if (st_r.period_cnt == 8'h00) begin // [RL5]
					st_nxt.period_cnt = MEAS_PERIOD;
					nxt_hit = find_next(act_mask, 5'h00); // [RL11]
					if (nxt_hit[4]) begin
						st_nxt.btn = nxt_hit[3:0];
						st_nxt.phase = TAS_CONVERT;
					end
				end
			end
			TAS_CONVERT: begin
				if (st_r.cal[st_r.btn] && st_r.cal_step == 4'h0) begin
					// Successive approximation starts at mid-scale
					st_nxt.cap[st_r.btn] = `TAS_CAP_MID; // [RL3]
					st_nxt.cal_bit = `TAS_CAP_MID;
					st_nxt.cap_out = `TAS_CAP_MID;
				end else begin
					st_nxt.cap_out = st_r.cap[st_r.btn];
				end
				st_nxt.adc_start = 1'b1; // [RL1]
				st_nxt.adc_btn = st_r.btn;
				st_nxt.phase = TAS_WAIT;
			end
			TAS_WAIT: begin
				if (done_evt) begin
					st_nxt.sig = st_r.data_s2; // [RL1]
					st_nxt.phase = TAS_EVAL;
				end
			end
			TAS_EVAL: begin
				// A request landing mid-measurement waits for its next
				// conversion; only a started search is continued here
				if (st_r.cal[st_r.btn] &&
						(st_r.cal_step != 4'h0 || st_r.cal_bit != '0)) begin
					if (st_r.cal_step != `TAS_CAL_STEPS) begin
						// Low signal means the trial capacitor is too large
						if (st_r.sig < `TAS_CAL_TARGET) begin // [RL3]
							trial = trial & ~st_r.cal_bit;
						end
						st_nxt.cal_bit = st_r.cal_bit >> 1;
						trial = trial | st_nxt.cal_bit;
						st_nxt.cap[st_r.btn] = trial;
						st_nxt.cal_step = st_r.cal_step + 4'h1;
						st_nxt.phase = TAS_CONVERT;
					end else begin
						// Last conversion with matched capacitor
						st_nxt.refv[st_r.btn] = st_r.sig; // [RL4]
						st_nxt.cal[st_r.btn] = 1'b0; // [RL23]
						st_nxt.cal_step = 4'h0;
						st_nxt.touch[st_r.btn] = 1'b0;
						st_nxt.dcnt[st_r.btn] = 4'h0;
						advance = 1'b1;
					end
				end else begin
					// Only calibrated buttons reach detection
					st_nxt.delta = cur_delta; // [RL2] [RL6]
					st_nxt.touch[st_r.btn] = det_touch; // [RL7] [RL8]
					st_nxt.dcnt[st_r.btn] = det_cnt;
					// Drift one count per quiet measurement; slow but it
					// keeps the reference from chasing a slow touch
					if (st_r.touch == '0 && det_cnt == 4'h0) begin // [RL9]
						if (cur_delta > 0) begin
							st_nxt.refv[st_r.btn] = st_r.refv[st_r.btn] + 1'b1;
						end else if (cur_delta < 0) begin
							st_nxt.refv[st_r.btn] = st_r.refv[st_r.btn] - 1'b1;
						end
					end
					advance = 1'b1;
				end
				if (advance) begin
					st_nxt.phase = TAS_IDLE;
					if (st_r.btn != `TAS_LAST_BTN) begin
						nxt_hit = find_next(act_mask, {1'b0, st_r.btn} + 5'h01); // [RL11] [RL13]
						if (nxt_hit[4]) begin
							st_nxt.btn = nxt_hit[3:0];
							st_nxt.phase = TAS_CONVERT;
						end
					end
					if (st_nxt.phase == TAS_IDLE &&
							(st_nxt.cal & sense_mask) == '0) begin
						st_nxt.init_done = 1'b1; // [RL2]
					end
				end
			end
		endcase

		st_nxt.drift_frozen = (st_nxt.touch != '0); // [RL9]

		// Request bits win over the self-clear in the same cycle
		st_nxt.cal = st_nxt.cal | CAL_REQ; // [RL20] [RL23]

		// Every sensing button suspended: nothing left to scan
		stuck = (sense_mask != '0) && (act_mask == '0);
		if (stuck && WDT_ENABLE) begin // [RL14]
			st_nxt.wdt_cnt = st_r.wdt_cnt + 1'b1;
		end else begin
			st_nxt.wdt_cnt = '0;
		end
		wdt_fire = stuck && WDT_ENABLE &&
			(st_r.wdt_cnt == `TAS_CNT_W'(`TAS_WDT_CYCLES - 1)); // [RL14]
		st_nxt.wdt_rst = wdt_fire;
		restart = RESTART || wdt_fire;

		if (restart) begin
			st_nxt.en_act = st_r.en_saved; // [RL16]
			st_nxt.susp = '0; // [RL19]
			st_nxt.cal = st_r.en_saved; // [RL2]
			st_nxt.touch = '0;
			st_nxt.dcnt = '0;
			st_nxt.cal_step = 4'h0;
			st_nxt.cal_bit = '0;
			st_nxt.period_cnt = 8'h00;
			st_nxt.init_done = 1'b0;
			st_nxt.drift_frozen = 1'b0;
			st_nxt.phase = TAS_IDLE;
		end

		// Hardware reset stands for power-up: stored enables return to default
		if (!RESET_N) begin
			st_nxt = '0;
			// Synchroniser keeps following the pin, so no false done
			// edge appears once reset is released
			st_nxt.done_s1 = ADC_DONE;
			st_nxt.done_s2 = st_r.done_s1;
			st_nxt.done_s3 = st_r.done_s2;
			st_nxt.en_pend = `TAS_EN_DEFAULT; // [RL12]
			st_nxt.en_saved = `TAS_EN_DEFAULT;
			st_nxt.en_act = `TAS_EN_DEFAULT; // [RL10] [RL12]
			st_nxt.cal = `TAS_EN_DEFAULT; // [RL2] [RL19]
		end
	end

	always_ff @(posedge CLK) begin
		st_r <= st_nxt;
	end

	assign ADC_START = st_r.adc_start;
	assign ADC_BUTTON = st_r.adc_btn;
	assign COMP_CAP = st_r.cap_out;
	assign TOUCH = st_r.touch;
	assign CAL_PENDING = st_r.cal;
	assign ENABLED = st_r.en_act;
	assign SUSPENDED = st_r.susp;
	assign SIGNAL = st_r.sig;
	assign DELTA = st_r.delta;
	assign DRIFT_FROZEN = st_r.drift_frozen;
	assign CAL_DONE = st_r.init_done;
	assign WDT_RESET = st_r.wdt_rst;

endmodule // tas_top

`default_nettype wire

// File: tb/tas_front_model.sv
// Behavioural analog front end: one conversion per start, done by toggle.
// Signal falls as the capacitor setting rises; matched setting is MATCH.
`timescale 1ns/1ps
`default_nettype none

module tas_front_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [3:0] btn,
	input wire logic [7:0] cap,
	input wire logic slow,
	input wire tas_pkg::tas_mask_t tmask,
	input wire logic [9:0] tadd,
	output logic done,
	output logic [9:0] data
);
	import tas_pkg::*;
	localparam logic [7:0] MATCH = 8'h55;
	logic [3:0] b_r;
	logic [7:0] c_r;
	logic [4:0] cnt_r;
	logic tog_r;
	initial begin
		done = 1'b0;
		data = 10'h0;
		cnt_r = 5'h0;
		tog_r = 1'b0;
	end
	// A new start cancels any answer still owed, so restarts stay in step
	always @(posedge clk) begin
		if (start) begin
			b_r <= btn;
			c_r <= cap;
			cnt_r <= slow ? 5'h14 : 5'h2;
			tog_r <= 1'b0;
			data <= ~data;
		end else if (cnt_r > 5'h1) begin
			cnt_r <= cnt_r - 5'h1;
		end else if (cnt_r == 5'h1) begin
			cnt_r <= 5'h0;
			tog_r <= 1'b1;
			data <= 10'h200 + {2'h0, MATCH} - {2'h0, c_r} +
				(tmask[b_r] ? tadd : 10'h0);
		end else if (tog_r) begin
			done <= ~done;
			tog_r <= 1'b0;
		end
	end
endmodule // tas_front_model

`default_nettype wire

// File: tb/tas_top_bench.sv
// Self-checking bench of the sequencer with a front end model.
// Assumes design, checker and model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < n) begin step(1); k++; \
	end if (!(c)) begin num_errors++; final_report; end end

module tas_top_bench;
	import tas_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, en_wr = 1'b0, persist = 1'b0;
	logic restart = 1'b0, susp_wr = 1'b0, shield = 1'b0, wdt_en = 1'b0;
	logic slow = 1'b0, adc_start, adc_done, drift, cal_done, wdt_rst;
	tas_mask_t en_data = 16'h0, susp_data = 16'h0, cal_req = 16'h0;
	tas_mask_t tmask = 16'h0, touch, cal_pend, enabled, susp, seen;
	logic [7:0] period = 8'h0, comp_cap;
	logic [9:0] tadd = 10'h0, adc_data, sig;
	logic [3:0] adc_btn;
	logic [1:0] hsel = 2'h0;
	tas_delta_t delta, d1;
	int num_errors = 0, cmp_count = 0, k, cyc = 0, last0 = 0, gap = 0;
	tas_top tas_top_i (.CLK(clk), .RESET_N(rst_n), .EN_WR(en_wr),
		.EN_DATA(en_data), .PERSIST(persist), .RESTART(restart),
		.SUSP_WR(susp_wr), .SUSP_DATA(susp_data), .CAL_REQ(cal_req),
		.SHIELD_MODE(shield), .WDT_ENABLE(wdt_en), .THRESHOLD(8'h28),
		.HYST_SEL(hsel), .DI_LIMIT(4'h2), .MEAS_PERIOD(period),
		.ADC_DONE(adc_done), .ADC_DATA(adc_data), .ADC_START(adc_start),
		.ADC_BUTTON(adc_btn), .COMP_CAP(comp_cap), .TOUCH(touch),
		.CAL_PENDING(cal_pend), .ENABLED(enabled), .SUSPENDED(susp),
		.SIGNAL(sig), .DELTA(delta), .DRIFT_FROZEN(drift),
		.CAL_DONE(cal_done), .WDT_RESET(wdt_rst));
	tas_front_model tas_front_model_i (.clk(clk), .start(adc_start),
		.btn(adc_btn), .cap(comp_cap), .slow(slow), .tmask(tmask),
		.tadd(tadd), .done(adc_done), .data(adc_data));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (adc_start)
			seen[adc_btn] = 1'b1;
		if (adc_start && adc_btn == 4'h0) begin
			gap = cyc - last0;
			last0 = cyc;
		end
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task suspend(input tas_mask_t m);
		susp_data = m;
		susp_wr = 1'b1;
		step(1);
		susp_wr = 1'b0;
	endtask
	task final_report;
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		step(3);
		`CHK(enabled, 16'h0FFF)
		`CHK(cal_pend, 16'h0FFF)
		rst_n = 1'b1;
		seen = 16'h0;
		`WAITC(cal_done === 1'b1, 3000)
		`CHK(cal_pend, 16'h0000)
		`CHK(seen, 16'h0FFF)
		`CHK(comp_cap, 8'h55)
		step(200);
		`CHK(sig, 10'h200)
		`CHK(delta, 11'sh000)
		tmask = 16'hFFFF;
		tadd = 10'h03C;
		`WAITC(touch === 16'h0FFF, 1500)
		`CHK(drift, 1'b1)
		d1 = delta;
		step(600);
		`CHK(delta, d1)
		tadd = 10'h01E;
		step(300);
		`CHK(touch, 16'h0FFF)
		`CHK(delta, d1 - 11'sh01E)
		hsel = 2'h1;
		tadd = 10'h019;
		`WAITC(touch === 16'h0000, 1500)
		tadd = 10'h0;
		step(2);
		`CHK(drift, 1'b0)
		slow = 1'b1;
		suspend(16'h0020);
		step(1);
		`CHK(susp, 16'h0020)
		step(300);
		seen = 16'h0;
		step(700);
		`CHK(seen[6:5], 2'b10)
		suspend(16'h0);
		seen = 16'h0;
		step(700);
		`CHK(seen[5], 1'b1)
		slow = 1'b0;
		cal_req = 16'h0020;
		step(1);
		cal_req = 16'h0;
		step(1);
		`CHK(cal_pend, 16'h0020)
		`WAITC(cal_pend === 16'h0, 800)
		`CHK(cal_pend, 16'h0000)
		shield = 1'b1;
		step(200);
		seen = 16'h0;
		step(300);
		`CHK(seen[11:10], 2'b01)
		shield = 1'b0;
		en_data = 16'h00FF;
		en_wr = 1'b1;
		step(1);
		en_wr = 1'b0;
		persist = 1'b1;
		step(1);
		persist = 1'b0;
		restart = 1'b1;
		`CHK(enabled, 16'h0FFF)
		step(1);
		restart = 1'b0;
		step(1);
		`CHK(enabled, 16'h00FF)
		`CHK(cal_pend, 16'h00FF)
		`WAITC(cal_done === 1'b1, 3000)
		seen = 16'h0;
		step(300);
		`CHK(seen, 16'h00FF)
		wdt_en = 1'b1;
		suspend(16'h00FF);
		`WAITC(wdt_rst === 1'b1, 2600)
		`CHK(k >= 1995, 1'b1)
		step(1);
		`CHK(susp, 16'h0000)
		wdt_en = 1'b0;
		period = 8'h01;
		`WAITC(cal_done === 1'b1, 3000)
		step(2500);
		`CHK(gap >= 1000 && gap < 1100, 1'b1)
		rst_n = 1'b0;
		step(2);
		`CHK(enabled, 16'h0FFF)
		final_report;
	end
endmodule // tas_top_bench

`default_nettype wire

// File: tb/tas_top_props.sv
// Checker of the sequencer's port behaviour, bound into tas_top.
// Assumes tas_pkg is compiled first; sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none

module tas_top_props (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic EN_WR,
	input wire logic RESTART,
	input wire tas_pkg::tas_mask_t CAL_REQ,
	input wire logic SHIELD_MODE,
	input wire logic [7:0] THRESHOLD,
	input wire logic [1:0] HYST_SEL,
	input wire logic ADC_START,
	input wire logic [3:0] ADC_BUTTON,
	input wire tas_pkg::tas_mask_t TOUCH,
	input wire tas_pkg::tas_mask_t CAL_PENDING,
	input wire tas_pkg::tas_mask_t ENABLED,
	input wire tas_pkg::tas_mask_t SUSPENDED,
	input wire tas_pkg::tas_delta_t DELTA,
	input wire logic DRIFT_FROZEN,
	input wire logic CAL_DONE,
	input wire logic WDT_RESET
);
	import tas_pkg::*;
	logic [32:0] prev_r;
	logic [2:0] age_r;
	tas_delta_t thr;
	tas_delta_t rel;
	assign thr = $signed({3'h0, THRESHOLD});
	assign rel = thr - $signed({3'h0, THRESHOLD >> (3'h1 + HYST_SEL)});
	// Scan choice lags the masks, so only settled masks are judged
	always_ff @(posedge CLK) begin
		prev_r <= {ENABLED, SUSPENDED, SHIELD_MODE};
		if (!RESET_N || prev_r != {ENABLED, SUSPENDED, SHIELD_MODE})
			age_r <= 3'h0;
		else if (age_r != 3'h4)
			age_r <= age_r + 3'h1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_rst;
		@(posedge CLK) disable iff (1'b0)
		!RESET_N |=> ENABLED == 16'h0FFF && CAL_PENDING == 16'h0FFF && TOUCH == 16'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset values");
	property p_pulse;
		ADC_START |=> !ADC_START;
	endproperty
	a_pulse: assert property (p_pulse) else $error("start too long");
	property p_skip;
		ADC_START && age_r == 3'h4 |-> ENABLED[ADC_BUTTON] &&
			!SUSPENDED[ADC_BUTTON] && !(SHIELD_MODE && ADC_BUTTON == 4'hB);
	endproperty
	a_skip: assert property (p_skip) else $error("inactive scanned");
	property p_frozen;
		(TOUCH != 16'h0) |-> ##[0:1] DRIFT_FROZEN;
	endproperty
	a_frozen: assert property (p_frozen) else $error("drift not frozen");
	property p_thaw;
		(TOUCH == 16'h0) [*2] |-> !DRIFT_FROZEN;
	endproperty
	a_thaw: assert property (p_thaw) else $error("drift stuck frozen");
	property p_touch;
		(TOUCH & ~$past(TOUCH)) != 16'h0 |-> DELTA > thr;
	endproperty
	a_touch: assert property (p_touch) else $error("touch below threshold");
	property p_release;
		(~TOUCH & $past(TOUCH)) != 16'h0 && !$past(RESTART) && !WDT_RESET &&
			!$past(WDT_RESET) |-> DELTA < rel;
	endproperty
	a_release: assert property (p_release) else $error("early release");
	property p_cal_set;
		(CAL_REQ != 16'h0) |=> (CAL_PENDING & $past(CAL_REQ)) == $past(CAL_REQ);
	endproperty
	a_cal_set: assert property (p_cal_set) else $error("cal not pending");
	property p_wdt;
		WDT_RESET |-> ##[0:1] SUSPENDED == 16'h0;
	endproperty
	a_wdt: assert property (p_wdt) else $error("suspends kept");
	property p_restart;
		RESTART |=> SUSPENDED == 16'h0 && TOUCH == 16'h0 && !CAL_DONE;
	endproperty
	a_restart: assert property (p_restart) else $error("restart incomplete");
	property p_en_wr;
		EN_WR && !RESTART |=> ENABLED == $past(ENABLED) || WDT_RESET;
	endproperty
	a_en_wr: assert property (p_en_wr) else $error("enable acted early");
	c_touch: cover property (TOUCH != 16'h0);
	c_wdt: cover property (WDT_RESET);
	c_cal: cover property ($rose(CAL_DONE));
endmodule // tas_top_props

bind tas_top tas_top_props tas_top_props_i (.CLK(CLK), .RESET_N(RESET_N),
	.EN_WR(EN_WR), .RESTART(RESTART), .CAL_REQ(CAL_REQ),
	.SHIELD_MODE(SHIELD_MODE), .THRESHOLD(THRESHOLD), .HYST_SEL(HYST_SEL),
	.ADC_START(ADC_START), .ADC_BUTTON(ADC_BUTTON), .TOUCH(TOUCH),
	.CAL_PENDING(CAL_PENDING), .ENABLED(ENABLED), .SUSPENDED(SUSPENDED),
	.DELTA(DELTA), .DRIFT_FROZEN(DRIFT_FROZEN), .CAL_DONE(CAL_DONE),
	.WDT_RESET(WDT_RESET));

`default_nettype wire
